/* File: rtl/sac_adc_ctrl.sv */
// Conversion control for a 10-bit successive-approximation converter.
// Assumes an APB master, an analog core that compares the selected
// input with the trial code, and stop mode as a synchronous level.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps

// Notes on behaviour
// - Comparator always high gives 3ff, always low gives 000.
// - Control write starts a conversion of 16 to 17 converter clocks.
// - Continuous mode overwrites the result, read or not, unless an interlocked high read locked it.
// - Continuous mode restarts until the continuous bit is cleared.
// - Done flag sets at conversion end, clears on data read.
// - Single mode does one conversion per control write, then idles.
// - Two format bits in clock register choose one of four formats.
// - Left format: top eight bits high, two low bits low.
// - Interlocked formats: read low after high; new results refused.
// - Right format: top two bits high, low eight bits low.
// - Signed format: left layout with result top bit inverted.
// - Truncation format: top eight bits in low, no interlock.
// - Interrupt enabled: request raised after each conversion whose result is stored.
// - Interrupt enabled: done flag is not set.
// - Converting continues in wait; request can wake the processor.
// - Stop mode makes the block inactive and aborts conversion.
// - After stop, conversions resume; first only settles analog.
// - One of 24 input channels is selected by the multiplexer.
// - Done flag read-only, cleared by data read; zero if enabled.
// - Code 1f powers off, 1d upper, 1e lower, 00-17 channels.
// - In interlocked formats, reading high freezes the low register until low is read.
// - Request cleared by data read or control write.
module sac_adc_ctrl
    import sac_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [SAC_AW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic osc_tick_in,
    input wire logic stop_mode_in,
    input wire logic comparator_in,
    output logic [4:0] channel_out,
    output logic power_on_out,
    output logic sample_out,
    output logic [9:0] trial_code_out,
    output logic irq_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sac_state_t st;
        logic [4:0] cnt;
        logic [9:0] sar;
        logic [9:0] bitm;
        logic [9:0] res;
        logic lock;
        logic done;
        logic irq;
        logic settle;
        logic resume;
        logic stop;
        logic [4:0] chan;
        logic cont;
        logic ien;
        logic [2:0] div;
        logic src;
        logic [1:0] fmt;
        logic pwr;
        logic smp;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [9:0] runc;
    } sac_regs_t;

    sac_regs_t s_q;
    sac_regs_t s_d;

    logic tick;
    logic acc;
    logic cap;
    logic xfer;
    logic hit;
    logic wr_ctrl;
    logic wr_clk;
    logic rd_hi;
    logic rd_lo;
    logic conv_end;
    logic conv_fin;
    logic ilock;
    logic store_ok;
    logic [9:0] nb;
    logic [7:0] rhi;
    logic [7:0] rlo;
    logic [4:0] divn;

    sac_prescaler sac_prescaler_i (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .src_bus_in(s_q.src),
        .osc_tick_in(osc_tick_in),
        .div_sel_in(s_q.div),
        .tick_out(tick)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // One wait state: data and read side effects land on first access
    assign acc = psel_in & penable_in;
    assign cap = acc & ~s_q.pready;
    assign xfer = acc & s_q.pready;
    assign hit = (paddr_in == SAC_OFS_CTRL) | (paddr_in == SAC_OFS_RHI) |
                 (paddr_in == SAC_OFS_RLO) | (paddr_in == SAC_OFS_CLK);
    assign wr_ctrl = xfer & pwrite_in & (paddr_in == SAC_OFS_CTRL);
    assign wr_clk = xfer & pwrite_in & (paddr_in == SAC_OFS_CLK);
    assign rd_hi = cap & ~pwrite_in & (paddr_in == SAC_OFS_RHI);
    assign rd_lo = cap & ~pwrite_in & (paddr_in == SAC_OFS_RLO);

    // ------------------------------------------------------------
    // Result formatting
    // ------------------------------------------------------------
    assign ilock = (s_q.fmt != SAC_FMT_TRUNC);
    assign rhi = (s_q.fmt == SAC_FMT_RIGHT) ? {6'h00, s_q.res[9:8]} :
                 (s_q.fmt == SAC_FMT_TRUNC) ? 8'h00 :
                 {s_q.res[9] ^ (s_q.fmt == SAC_FMT_SIGNED),
                  s_q.res[8:2]};
    assign rlo = (s_q.fmt == SAC_FMT_RIGHT) ? s_q.res[7:0] :
                 (s_q.fmt == SAC_FMT_TRUNC) ? s_q.res[9:2] :
                 {s_q.res[1:0], 6'h00};

    // ------------------------------------------------------------
    // Conversion events
    // ------------------------------------------------------------
    assign conv_end = (s_q.st == SAC_RUN) & tick &
                      (s_q.cnt == SAC_CONV_TICKS - 5'h01);
    // A control write in the same cycle aborts the finishing conversion
    assign conv_fin = conv_end & ~wr_ctrl;
    assign store_ok = ~(s_q.lock & ilock);
    assign nb = s_q.bitm >> 1;
    assign divn = s_q.div[2] ? 5'h10 : (5'h01 << s_q.div[1:0]);

    always_comb begin
        s_d = s_q;
        s_d.runc = s_q.runc + 10'h001;

        // Bus answer
        s_d.pready = cap;
        s_d.pslverr = cap & ~hit;
        s_d.prdata = 32'h0000_0000;
        if (cap && !pwrite_in) begin
            if (paddr_in == SAC_OFS_CTRL) begin
                s_d.prdata[SAC_CTRL_CH_LSB +: 5] = s_q.chan;
                s_d.prdata[SAC_CTRL_CONT] = s_q.cont;
                s_d.prdata[SAC_CTRL_IEN] = s_q.ien;
                s_d.prdata[SAC_CTRL_DONE] = s_q.done & ~s_q.ien;
            end else if (paddr_in == SAC_OFS_RHI) begin
                s_d.prdata[7:0] = rhi;
            end else if (paddr_in == SAC_OFS_RLO) begin
                s_d.prdata[7:0] = rlo;
            end else if (paddr_in == SAC_OFS_CLK) begin
                s_d.prdata[SAC_CLK_FMT_LSB +: 2] = s_q.fmt;
                s_d.prdata[SAC_CLK_SRC] = s_q.src;
                s_d.prdata[SAC_CLK_DIV_LSB +: 3] = s_q.div;
            end
        end

        // Read side effects
        if (rd_hi && ilock) begin
            s_d.lock = 1'b1;
        end
        if (rd_lo) begin
            s_d.lock = 1'b0;
        end
        if (rd_hi || rd_lo) begin
            s_d.done = 1'b0;
            s_d.irq = 1'b0;
        end

        // Conversion sequencer
        case (s_q.st)
            SAC_IDLE: begin
                s_d.st = SAC_IDLE;
            end
            SAC_RUN: begin
                if (tick) begin
                    s_d.cnt = s_q.cnt + 5'h01;
                    if (s_q.cnt == SAC_SAMPLE_END) begin
                        s_d.sar = SAC_SAR_MSB;
                        s_d.bitm = SAC_SAR_MSB;
                    end else if (s_q.bitm != 10'h000) begin
                        // Keep the trial bit only while input >= trial
                        s_d.sar = (comparator_in ? s_q.sar :
                                   s_q.sar & ~s_q.bitm) | nb;
                        s_d.bitm = nb;
                    end
                end
                if (conv_fin) begin
                    s_d.cnt = 5'h00;
                    s_d.runc = 10'h000;
                    if (s_q.settle) begin
                        // Settling pass: result thrown away, go again
                        s_d.settle = 1'b0;
                    end else begin
                        if (store_ok) begin
                            s_d.res = s_q.sar;
                            if (s_q.ien) begin
                                s_d.irq = 1'b1;
                            end else begin
                                s_d.done = 1'b1;
                            end
                        end
                        if (!s_q.cont) begin
                            s_d.st = SAC_IDLE;
                        end else begin
                            s_d.st = SAC_RUN;
                        end
                    end
                end
            end
            SAC_HALT: begin
                if (!stop_mode_in) begin
                    s_d.st = s_q.resume ? SAC_RUN : SAC_IDLE;
                    s_d.settle = 1'b1;
                    s_d.cnt = 5'h00;
                    s_d.runc = 10'h000;
                end
            end
            default: begin
                s_d.st = SAC_IDLE;
            end
        endcase

        // Register writes
        if (wr_ctrl) begin
            s_d.chan = pwdata_in[SAC_CTRL_CH_LSB +: 5];
            s_d.cont = pwdata_in[SAC_CTRL_CONT];
            s_d.ien = pwdata_in[SAC_CTRL_IEN];
            s_d.irq = 1'b0;
            s_d.cnt = 5'h00;
            s_d.runc = 10'h000;
            if (s_d.chan == SAC_CH_OFF) begin
                s_d.st = SAC_IDLE;
                s_d.settle = 1'b1;
            end else begin
                s_d.st = SAC_RUN;
            end
        end
        if (wr_clk) begin
            s_d.fmt = pwdata_in[SAC_CLK_FMT_LSB +: 2];
            s_d.src = pwdata_in[SAC_CLK_SRC];
            s_d.div = pwdata_in[SAC_CLK_DIV_LSB +: 3];
        end

        // Stop overrides everything; the pending work is remembered
        s_d.stop = stop_mode_in;
        if (stop_mode_in) begin
            if (!s_q.stop) begin
                s_d.resume = (s_d.st == SAC_RUN) | s_d.cont;
            end
            s_d.st = SAC_HALT;
            s_d.cnt = 5'h00;
            s_d.bitm = 10'h000;
        end

        // Analog core controls
        s_d.pwr = (s_d.chan != SAC_CH_OFF) & ~stop_mode_in;
        s_d.smp = (s_d.st == SAC_RUN) & (s_d.cnt >= SAC_SAMPLE_BEG) &
                  (s_d.cnt <= SAC_SAMPLE_END);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
            s_q.st <= SAC_IDLE;
            s_q.chan <= SAC_CH_RST;
            s_q.div <= SAC_DIV_RST;
            s_q.src <= SAC_SRC_RST;
            s_q.settle <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_out = s_q.prdata;
    assign pready_out = s_q.pready;
    assign pslverr_out = s_q.pslverr;
    assign channel_out = s_q.chan;
    assign power_on_out = s_q.pwr;
    assign sample_out = s_q.smp;
    assign trial_code_out = s_q.sar;
    // Not gated by wait mode, so it can wake the processor
    assign irq_out = s_q.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_conv_time_span: assert property (
        conv_end && s_q.src && !$changed(s_q.div) |->
        int'(s_q.runc) + 1 >= 16 * int'(divn) &&
        int'(s_q.runc) + 1 <= 17 * int'(divn))
        else $error("conversion length outside 16 to 17 converter clocks");

    a_single_goes_idle: assert property (
        conv_fin && !s_q.cont && !s_q.settle && !stop_mode_in
        |=> s_q.st == SAC_IDLE)
        else $error("single conversion did not return to idle");

    a_cont_restarts: assert property (
        conv_fin && s_q.cont && !stop_mode_in
        |=> s_q.st == SAC_RUN && s_q.cnt == 5'h00)
        else $error("continuous mode did not restart");

    a_done_after_end: assert property (
        conv_fin && !s_q.settle && store_ok && !s_q.ien
        |=> s_q.done ##1 (s_q.done || $past(rd_hi || rd_lo)))
        else $error("done flag not set or lost without a data read");

    a_flag_zero_ien: assert property (
        s_q.ien && !s_q.done |=> !s_q.done)
        else $error("done flag set while interrupts enabled");

    a_irq_after_end: assert property (
        conv_fin && !s_q.settle && store_ok && s_q.ien |=> irq_out)
        else $error("interrupt not raised at conversion end");

    a_irq_clr_write: assert property (
        wr_ctrl |=> !irq_out)
        else $error("interrupt not cleared by control write");

    a_lock_hold_res: assert property (
        s_q.lock && ilock && !rd_lo |=> $stable(s_q.res))
        else $error("result changed while interlocked");

    a_stop_halts: assert property (
        stop_mode_in |=> (s_q.st == SAC_HALT && !sample_out))
        else $error("converter still active in stop mode");

    a_answer_one_wait: assert property (
        psel_in && penable_in && !pready_out |=> pready_out)
        else $error("bus answer not given after one wait state");

    c_cont_two: cover property (
        conv_fin && s_q.cont ##[1:400] conv_fin);
    c_lock_refuse: cover property (conv_fin && !store_ok);
    c_stop_run: cover property (
        s_q.st == SAC_RUN && stop_mode_in ##[1:20] !stop_mode_in);

endmodule : sac_adc_ctrl

/* File: pkg/sac_pkg.sv */
// Shared constants for the converter control block: register map,
// field positions, reset values, format codes and conversion timing.
// Assumes a 32-bit APB with byte addresses and one word per register.
package sac_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int SAC_AW = 8;
    localparam logic [SAC_AW-1:0] SAC_OFS_CTRL = 8'h00;
    localparam logic [SAC_AW-1:0] SAC_OFS_RHI = 8'h04;
    localparam logic [SAC_AW-1:0] SAC_OFS_RLO = 8'h08;
    localparam logic [SAC_AW-1:0] SAC_OFS_CLK = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SAC_CTRL_CH_LSB = 0;
    localparam int SAC_CTRL_CONT = 5;
    localparam int SAC_CTRL_IEN = 6;
    localparam int SAC_CTRL_DONE = 7;
    localparam int SAC_CLK_FMT_LSB = 2;
    localparam int SAC_CLK_SRC = 4;
    localparam int SAC_CLK_DIV_LSB = 5;

    // ------------------------------------------------------------
    // Channel codes and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] SAC_CH_LAST = 5'h17;
    localparam logic [4:0] SAC_CH_UPREF = 5'h1d;
    localparam logic [4:0] SAC_CH_LOREF = 5'h1e;
    localparam logic [4:0] SAC_CH_OFF = 5'h1f;
    localparam logic [4:0] SAC_CH_RST = 5'h1f;
    localparam logic [2:0] SAC_DIV_RST = 3'h0;
    localparam logic SAC_SRC_RST = 1'b0;

    // ------------------------------------------------------------
    // Result formats
    // ------------------------------------------------------------
    localparam logic [1:0] SAC_FMT_LEFT = 2'h0;
    localparam logic [1:0] SAC_FMT_RIGHT = 2'h1;
    localparam logic [1:0] SAC_FMT_SIGNED = 2'h2;
    localparam logic [1:0] SAC_FMT_TRUNC = 2'h3;

    // ------------------------------------------------------------
    // Conversion timing, in converter clock ticks
    // ------------------------------------------------------------
    localparam logic [4:0] SAC_CONV_TICKS = 5'h11;
    localparam logic [4:0] SAC_SAMPLE_BEG = 5'h01;
    localparam logic [4:0] SAC_SAMPLE_END = 5'h02;
    localparam logic [9:0] SAC_SAR_MSB = 10'h200;
    localparam logic [9:0] SAC_FULL_SCALE = 10'h3ff;

    typedef enum logic [2:0] {
        SAC_IDLE = 3'b001,
        SAC_RUN = 3'b010,
        SAC_HALT = 3'b100
    } sac_state_t;

endpackage : sac_pkg

/* File: rtl/sac_prescaler.sv */
// Converter clock prescaler: turns the selected source into a tick.
// Assumes the oscillator tick input is a one-cycle pulse on clk_in.
`timescale 1ns/100ps
module sac_prescaler
    import sac_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic src_bus_in,
    input wire logic osc_tick_in,
    input wire logic [2:0] div_sel_in,
    output logic tick_out
);
    typedef struct packed {
        logic [3:0] cnt;
    } sac_psc_t;

    sac_psc_t s_q;
    sac_psc_t s_d;
    logic src_ev;
    logic [3:0] lim;

    assign src_ev = src_bus_in ? 1'b1 : osc_tick_in;
    // Divide by 1, 2, 4, 8, or 16 for any code with the top bit set
    assign lim = div_sel_in[2] ? 4'hf :
                 div_sel_in[1] ? (div_sel_in[0] ? 4'h7 : 4'h3) :
                 {3'h0, div_sel_in[0]};
    assign tick_out = src_ev & (s_q.cnt == lim);

    always_comb begin
        s_d = s_q;
        if (src_ev) begin
            // A shrinking divider restarts the count, never skips past it
            s_d.cnt = (s_q.cnt >= lim) ? 4'h0 : s_q.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : sac_prescaler

/* File: tb/sac_analog_model.sv */
// Behavioural analog core: channel mux, references and comparator.
// Assumes channel and trial code come registered from the controller.
`timescale 1ns/100ps
module sac_analog_model (
    input wire logic clk_in,
    input wire logic [4:0] channel_in,
    input wire logic power_on_in,
    input wire logic [9:0] trial_code_in,
    input wire logic [9:0] level_in,
    output logic comparator_out
);
    // ------------------------------------------------------------
    // Mux and comparator
    // ------------------------------------------------------------
    logic [9:0] vin;
    logic junk_q = 1'b0;

    // Unpowered core toggles, so a stale decision never looks valid
    always @(posedge clk_in) begin
        junk_q <= ~junk_q;
    end

    always_comb begin
        case (channel_in)
            5'h1d: vin = 10'h3ff;
            5'h1e: vin = 10'h000;
            default: vin = level_in;
        endcase
        comparator_out = power_on_in ? (vin >= trial_code_in) : junk_q;
    end
endmodule : sac_analog_model

/* File: tb/test_sar_adc_conversion_control.sv */
// Self-checking bench for the converter control block.
// Assumes bus clock source where exact conversion timing is checked.
`timescale 1ns/100ps
module test_sar_adc_conversion_control;
    import sac_pkg::*;
    // ------------------------------------------------------------
    // Clock, stimulus and instances
    // ------------------------------------------------------------
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [SAC_AW-1:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic osc_tick_in = 1'b0;
    logic [1:0] osc_cnt = 2'h0;
    logic stop_mode_in = 1'b0;
    logic [9:0] level = 10'h2a5;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic comparator_in;
    logic [4:0] channel_out;
    logic power_on_out;
    logic sample_out;
    int smp_n;
    logic [9:0] trial_code_out;
    logic irq_out;
    logic [31:0] r;
    int n;
    int bad_count = 0;
    int check_count = 0;

    always #12.5 clk_in = ~clk_in;

    // Oscillator source at a quarter of the bus rate
    always @(posedge clk_in) begin
        osc_cnt <= osc_cnt + 2'h1;
        osc_tick_in <= (osc_cnt == 2'h3);
    end

    sac_adc_ctrl sac_adc_ctrl_i (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .osc_tick_in(osc_tick_in),
        .stop_mode_in(stop_mode_in),
        .comparator_in(comparator_in),
        .channel_out(channel_out),
        .power_on_out(power_on_out),
        .sample_out(sample_out),
        .trial_code_out(trial_code_out),
        .irq_out(irq_out)
    );

    sac_analog_model sac_analog_model_i (
        .clk_in(clk_in),
        .channel_in(channel_out),
        .power_on_in(power_on_out),
        .trial_code_in(trial_code_out),
        .level_in(level),
        .comparator_out(comparator_in)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic give_up(input string nm);
        chk(nm, 32'h0, 32'h1);
        stop_test();
    endtask : give_up

    // Request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [SAC_AW-1:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int k;
        k = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            k++;
        end while (pready_out !== 1'b1 && k < 20);
        if (k >= 20) begin
            give_up("pready_wait");
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task automatic wr(input logic [SAC_AW-1:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        apb(1'b1, a, d, x, e);
    endtask : wr

    task automatic rd(input logic [SAC_AW-1:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask : rd

    task automatic wait_done;
        logic [31:0] x;
        int k;
        k = 0;
        do begin
            rd(SAC_OFS_CTRL, x);
            k++;
        end while (x[SAC_CTRL_DONE] !== 1'b1 && k < 40);
        if (k >= 40) begin
            give_up("done_wait");
        end
    endtask : wait_done

    // Counts cycles after the current edge until irq is seen
    task automatic wait_irq(output int c);
        smp_n = 0;
        c = 0;
        do begin
            @(posedge clk_in);
            #1;
            c++;
            if (sample_out === 1'b1) begin
                smp_n++;
            end
        end while (irq_out !== 1'b1 && c < 300);
        if (c >= 300) begin
            give_up("irq_wait");
        end
    endtask : wait_irq

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic e;
        chk("power_rst", {31'h0, power_on_out}, 32'h0);
        rd(SAC_OFS_CTRL, r);
        chk("ctrl_rst", r, 32'h1f);
        rd(SAC_OFS_CLK, r);
        chk("clk_rst", r, 32'h0);
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk("unmapped_err", {31'h0, e}, 32'h1);
        chk("unmapped_rd", r, 32'h0);
        wr(SAC_OFS_CTRL, 32'h9f);
        rd(SAC_OFS_CTRL, r);
        chk("done_ro", r, 32'h1f);
    endtask : t_reset

    task automatic t_formats;
        logic [4:0] chs [4] = '{5'h00, 5'h1d, 5'h1e, 5'h17};
        logic [9:0] v;
        logic [7:0] eh;
        logic [7:0] el;
        logic [1:0] f;
        for (int i = 0; i < 4; i++) begin
            f = 2'(i);
            v = (chs[i] == 5'h1d) ? 10'h3ff :
                (chs[i] == 5'h1e) ? 10'h000 : level;
            eh = v[9:2];
            el = {v[1:0], 6'h00};
            if (f == SAC_FMT_RIGHT) begin
                eh = {6'h00, v[9:8]};
                el = v[7:0];
            end
            if (f == SAC_FMT_SIGNED) begin
                eh[7] = ~v[9];
            end
            if (f == SAC_FMT_TRUNC) begin
                eh = 8'h00;
                el = v[9:2];
            end
            wr(SAC_OFS_CLK, {27'h0, 1'b1, f, 2'h0});
            wr(SAC_OFS_CTRL, {27'h0, chs[i]});
            wait_done();
            chk("chan_out", {27'h0, channel_out}, {27'h0, chs[i]});
            rd(SAC_OFS_RHI, r);
            chk("hi", r, {24'h0, eh});
            rd(SAC_OFS_RLO, r);
            chk("lo", r, {24'h0, el});
            rd(SAC_OFS_CTRL, r);
            chk("ctrl_read", r, {27'h0, chs[i]});
        end
    endtask : t_formats

    task automatic t_timing;
        wr(SAC_OFS_CLK, 32'h1c);
        wr(SAC_OFS_CTRL, 32'h45);
        wait_irq(n);
        chk("ticks_div1", n, 32'd17);
        chk("sample_div1", smp_n, 32'd2);
        rd(SAC_OFS_CTRL, r);
        chk("ctrl_ien", r, 32'h45);
        rd(SAC_OFS_RLO, r);
        chk("lo_trunc", r, {24'h0, level[9:2]});
        chk("irq_read", {31'h0, irq_out}, 32'h0);
        wr(SAC_OFS_CLK, 32'h3c);
        wr(SAC_OFS_CTRL, 32'h45);
        wait_irq(n);
        chk("ticks_div2", 32'(n >= 33 && n <= 34), 32'h1);
        wr(SAC_OFS_CLK, 32'hfc);
        wr(SAC_OFS_CTRL, 32'h45);
        wait_irq(n);
        chk("ticks_div16", 32'(n >= 257 && n <= 272), 32'h1);
        chk("sample_div16", smp_n, 32'd32);
        wr(SAC_OFS_CTRL, 32'h05);
        #1;
        chk("irq_write", {31'h0, irq_out}, 32'h0);
        wr(SAC_OFS_CLK, 32'h0c);
        wr(SAC_OFS_CTRL, 32'h45);
        wait_irq(n);
        chk("ticks_osc", 32'(n >= 65 && n <= 68), 32'h1);
    endtask : t_timing

    task automatic t_interlock;
        wr(SAC_OFS_CLK, 32'h10);
        wr(SAC_OFS_CTRL, 32'h25);
        wait_done();
        rd(SAC_OFS_RHI, r);
        chk("hi_first", r, 32'ha9);
        level <= 10'h15a;
        repeat (60) @(posedge clk_in);
        rd(SAC_OFS_CTRL, r);
        chk("ctrl_locked", r, 32'h25);
        rd(SAC_OFS_RLO, r);
        chk("lo_held", r, 32'h40);
        wait_done();
        rd(SAC_OFS_RHI, r);
        chk("hi_new", r, 32'h56);
        rd(SAC_OFS_RLO, r);
        chk("lo_new", r, 32'h80);
        wr(SAC_OFS_CLK, 32'h1c);
        rd(SAC_OFS_RHI, r);
        chk("hi_trunc", r, 32'h0);
        level <= 10'h0f0;
        repeat (60) @(posedge clk_in);
        rd(SAC_OFS_RLO, r);
        chk("lo_cont", r, 32'h3c);
        wr(SAC_OFS_CTRL, 32'h05);
        rd(SAC_OFS_RLO, r);
        wait_done();
        rd(SAC_OFS_RLO, r);
        repeat (60) @(posedge clk_in);
        rd(SAC_OFS_CTRL, r);
        chk("single_idle", r, 32'h05);
    endtask : t_interlock

    task automatic t_stop;
        wr(SAC_OFS_CTRL, 32'h45);
        repeat (8) @(posedge clk_in);
        stop_mode_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        chk("power_stop", {31'h0, power_on_out}, 32'h0);
        repeat (60) @(posedge clk_in);
        chk("irq_stop", {31'h0, irq_out}, 32'h0);
        stop_mode_in <= 1'b0;
        wait_irq(n);
        chk("ticks_resume", n, 32'd35);
        rd(SAC_OFS_RLO, r);
        chk("lo_resume", r, 32'h3c);
        wr(SAC_OFS_CTRL, 32'h1f);
        @(posedge clk_in);
        #1;
        chk("power_off", {31'h0, power_on_out}, 32'h0);
    endtask : t_stop

    initial begin
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_formats();
        t_timing();
        t_interlock();
        t_stop();
        stop_test();
    end
endmodule : test_sar_adc_conversion_control
